// File: src/fwc_map.vh
`ifndef FWC_MAP_VH
`define FWC_MAP_VH
// Register byte offsets on the 32-bit bus.
`define FWC_OFS_CTRL_HI     4'h0
`define FWC_OFS_SECT_LO     4'h4
`define FWC_OFS_STATUS      4'h8
`define FWC_OFS_ERROR       4'hC
// Fields of the write control high register.
`define FWC_BIT_START       15
`define FWC_BIT_SUSPEND_REQUEST        14
`define FWC_BIT_WPG         13
`define FWC_BIT_DOUBLE_WORD_PROGRAM_SELECT        12
`define FWC_BIT_SER         11
`define FWC_BIT_MODSEL      7
// Fields of the status register.
`define FWC_BIT_BUSY_EXT    0
`define FWC_BIT_BUSY_MAIN   1
`define FWC_BIT_PSUSP       2
`define FWC_BIT_ESUSP       3
// Sector field widths.
`define FWC_B2_SECTORS      3
`define FWC_B0_SECTORS      10
// Reset values.
`define FWC_RST_CTRL_HI     16'h0000
`define FWC_RST_SECT_LO     16'h0000
// Operation timing in cycles (pre-program, erase, program phases).
`define FWC_PREPROG_CYC     16'h0010
`define FWC_ERASE_CYC       16'h0020
`define FWC_PROG_CYC        16'h0008
`endif

// File: src/fwc_flash_write_control.v
// Summary of operation
// - Sector erase leaves every location of each selected sector reading all ones.
// - Erase needs one or more sectors of one bank; test sector never erasable.
// - Selected sectors are pre-programmed to zeros before the erase phase.
// - Sector erase select clears itself when erase completes.
// - Double-word program uses even-aligned address, data pairs zero and one.
// - Programming only turns ones into zeros, never zeros into ones.
// - Word program uses address and data pair zero, then write start.
// - Word and double-word select bits clear themselves on completion.
// - Suspend pauses running operation, bank returns to read, busy clears.
// - During program suspend only reads and program resume are accepted.
// - During erase suspend reads, erase resume and unsuspendable programs accepted.
// - Operations start only on write start; hardware clears it at end or suspend.
// - With the error flag high, write start is refused.
// - Software writing zero to write start has no effect.
// - Sector register bits refer to the module chosen by module select.
// - Extension module: three bits select and report bank 2 sectors.
// - Main module: ten bits select and report bank 0 sectors.
// - Erase sets sector status bits, cleared at end only without errors.
// - Module select zero means extension, one means main; cleared at end.
// - Suspend status bits only ever mean suspended; the error flag reads from its own register.
//
// The Wishbone interface to the registers and the address map were decided locally.
`include "fwc_map.vh"

module fwc_flash_write_control (
    // System
    input  wire        clk_sys,
    input  wire        rst_n,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Flash array command interface
    input  wire        flashError,
    output reg         flashProgPulse,
    output reg         flashErasePulse,
    output reg         flashPreProgPulse,
    output reg  [1:0]  flashBankBusy
);

    // Sequencer states.
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_PRE   = 3'h1;
    localparam [2:0] ST_ERASE = 3'h2;
    localparam [2:0] ST_PROG  = 3'h3;
    localparam [2:0] ST_DONE  = 3'h4;

    // Control register fields.
    reg        start_q;
    reg        suspend_request_q;
    reg        wpg_q;
    reg        double_word_program_select_q;
    reg        ser_q;
    reg        modSel_q;
    // Sector selection and status per module.
    reg [2:0]  b2Sect_q;
    reg [9:0]  b0Sect_q;
    // Sequencer state and the context kept across a suspend.
    reg [2:0]  state_q;
    reg [2:0]  savedState_q;
    reg [15:0] count_q;
    reg [15:0] savedCount_q;
    reg [2:0]  savedSel_q;
    reg        progSusp_q;
    reg        eraseSusp_q;
    reg        progInEsusp_q;
    reg        errSeen_q;
    // Error flag synchroniser.
    reg        errSync1_q;
    reg        errSync2_q;
    // Bank busy flags.
    reg        busyExt_q;
    reg        busyMain_q;

    // A request is taken once; the registered ack masks its second cycle.
    wire wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    wire wbRead  = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    wire wrCtrl  = wbWrite & (wb_adr_i == `FWC_OFS_CTRL_HI) & wb_sel_i[1];
    wire wrCtrlL = wbWrite & (wb_adr_i == `FWC_OFS_CTRL_HI) & wb_sel_i[0];
    wire wrSectL = wbWrite & (wb_adr_i == `FWC_OFS_SECT_LO) & wb_sel_i[0];
    wire wrSectH = wbWrite & (wb_adr_i == `FWC_OFS_SECT_LO) & wb_sel_i[1];
    wire errFlag = errSync2_q;
    wire nModSel = wrCtrlL ? wb_dat_i[`FWC_BIT_MODSEL] : modSel_q;

    // Sector field of the module that module select points at.
    function [9:0] sect_view;
        input       mainSel;
        input [9:0] mainBits;
        input [2:0] extBits;
        begin
            if (mainSel)
                sect_view = mainBits;
            else
                sect_view = {7'h00, extBits};
        end
    endfunction

    // An erase needs at least one sector of the module it is steered to.
    wire anySect  = |sect_view(nModSel, b0Sect_q, b2Sect_q);
    wire startReq = wrCtrl & wb_dat_i[`FWC_BIT_START];
    wire nWpg  = wrCtrl ? wb_dat_i[`FWC_BIT_WPG]  : wpg_q;
    wire nDwpg = wrCtrl ? wb_dat_i[`FWC_BIT_DOUBLE_WORD_PROGRAM_SELECT] : double_word_program_select_q;
    wire nSer  = wrCtrl ? wb_dat_i[`FWC_BIT_SER]  : ser_q;
    wire nSusp = wrCtrl ? wb_dat_i[`FWC_BIT_SUSPEND_REQUEST] : suspend_request_q;
    wire isProg = nWpg | nDwpg;
    // A start that names no operation or several at once is dropped.
    wire [1:0] opCount = {1'b0, nWpg} + {1'b0, nDwpg} + {1'b0, nSer};
    wire       oneOp   = (opCount == 2'h1);
    // Select bits of the request, matched against the suspended operation on resume.
    wire [2:0] reqSel  = {nWpg, nDwpg, nSer};

    // Decide whether a start request is acceptable in the current mode.
    function accept_start;
        input idle;
        input pSusp;
        input eSusp;
        input err;
        input suspend_request;
        input prog;
        input sector_erase_select;
        input any;
        input same;
        begin
            if (err | suspend_request | ~idle)
                accept_start = 1'b0;
            else if (pSusp)
                accept_start = prog & same;
            else if (eSusp)
                // A resume must name the operation that was suspended.
                accept_start = prog | (sector_erase_select & same);
            else
                accept_start = prog | (sector_erase_select & any);
        end
    endfunction

    // A refused start does not set the start bit.
    wire accept = startReq & oneOp &
                  accept_start(state_q == ST_IDLE, progSusp_q, eraseSusp_q, errFlag, nSusp,
                               isProg, nSer, anySect, reqSel == savedSel_q);
    // The pre-program phase hands over to the erase phase, so it never ends an operation.
    wire opDone = (state_q != ST_IDLE) && (count_q == 16'h0001) &&
                  (state_q != ST_PRE);
    // Programs started inside erase suspend cannot be suspended.
    wire suspNow = (state_q != ST_IDLE) && (state_q != ST_DONE) && suspend_request_q & ~progInEsusp_q;
    wire sectClear = (state_q == ST_DONE) && !progInEsusp_q && !(errSeen_q | errFlag);

    // The error flag is launched by the array's own timing, so two flops guard it.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            errSync1_q <= 1'b0;
            errSync2_q <= 1'b0;
        end else begin
            errSync1_q <= flashError;
            errSync2_q <= errSync1_q;
        end
    end

    // Software writes to sector bits land only while idle, so a running erase cannot be retargeted.
    // module steers sector field
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            b2Sect_q <= 3'h0;
            b0Sect_q <= 10'h000;
        end else if (sectClear) begin
            b2Sect_q <= 3'h0;
            b0Sect_q <= 10'h000;
        end else if (state_q == ST_IDLE) begin
            if (wrSectL && !modSel_q)
                b2Sect_q <= wb_dat_i[2:0];
            if (wrSectL && modSel_q)
                b0Sect_q[7:0] <= wb_dat_i[7:0];
            if (wrSectH && modSel_q)
                b0Sect_q[9:8] <= wb_dat_i[9:8];
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_q       <= 1'b0;
            suspend_request_q        <= 1'b0;
            wpg_q         <= 1'b0;
            double_word_program_select_q        <= 1'b0;
            ser_q         <= 1'b0;
            modSel_q      <= 1'b0;
            state_q       <= ST_IDLE;
            savedState_q  <= ST_IDLE;
            count_q       <= 16'h0000;
            progSusp_q    <= 1'b0;
            eraseSusp_q   <= 1'b0;
            progInEsusp_q <= 1'b0;
            errSeen_q     <= 1'b0;
            busyExt_q     <= 1'b0;
            busyMain_q    <= 1'b0;
            savedCount_q  <= 16'h0000;
            savedSel_q    <= 3'h0;
        end else begin
            if (wrCtrl && state_q == ST_IDLE) begin
                suspend_request_q <= wb_dat_i[`FWC_BIT_SUSPEND_REQUEST];
                wpg_q  <= wb_dat_i[`FWC_BIT_WPG];
                double_word_program_select_q <= wb_dat_i[`FWC_BIT_DOUBLE_WORD_PROGRAM_SELECT];
                ser_q  <= wb_dat_i[`FWC_BIT_SER];
            end else if (wrCtrl) begin
                suspend_request_q <= wb_dat_i[`FWC_BIT_SUSPEND_REQUEST];
            end
            if (wrCtrlL && state_q == ST_IDLE)
                modSel_q <= wb_dat_i[`FWC_BIT_MODSEL];
            if (errFlag)
                errSeen_q <= 1'b1;
            if (accept) begin
                start_q <= 1'b1;
                errSeen_q <= 1'b0;
                // steer busy by module
                // The module select written with the start steers this very operation.
                busyMain_q <= nModSel;
                busyExt_q  <= ~nModSel;
                // The remaining count comes back so a resumed operation does not end early.
                if (progSusp_q && isProg) begin
                    state_q <= savedState_q;
                    count_q <= savedCount_q;
                    progSusp_q <= 1'b0;
                end else if (eraseSusp_q && nSer && !isProg) begin
                    state_q <= savedState_q;
                    count_q <= savedCount_q;
                    eraseSusp_q <= 1'b0;
                end else if (isProg) begin
                    state_q <= ST_PROG;
                    count_q <= `FWC_PROG_CYC;
                    progInEsusp_q <= eraseSusp_q;
                end else begin
                    state_q <= ST_PRE;
                    count_q <= `FWC_PREPROG_CYC;
                end
            end else if (suspNow) begin
                savedState_q <= state_q;
                savedCount_q <= count_q;
                savedSel_q <= {wpg_q, double_word_program_select_q, ser_q};
                state_q <= ST_IDLE;
                start_q <= 1'b0;
                busyExt_q <= 1'b0;
                busyMain_q <= 1'b0;
                if (state_q == ST_PROG)
                    progSusp_q <= 1'b1;
                else
                    eraseSusp_q <= 1'b1;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        count_q <= count_q;
                    end
                    ST_PRE: begin
                        if (count_q == 16'h0001) begin
                            state_q <= ST_ERASE;
                            count_q <= `FWC_ERASE_CYC;
                        end else begin
                            count_q <= count_q - 16'h0001;
                        end
                    end
                    ST_ERASE, ST_PROG: begin
                        if (opDone)
                            state_q <= ST_DONE;
                        else
                            count_q <= count_q - 16'h0001;
                    end
                    ST_DONE: begin
                        state_q <= ST_IDLE;
                        start_q <= 1'b0;
                        busyExt_q <= 1'b0;
                        busyMain_q <= 1'b0;
                        // A program nested in an erase suspend leaves the erase context alone.
                        if (progInEsusp_q) begin
                            progInEsusp_q <= 1'b0;
                            wpg_q <= 1'b0;
                            double_word_program_select_q <= 1'b0;
                        end else begin
                            modSel_q <= 1'b0;
                            ser_q <= 1'b0;
                            wpg_q <= 1'b0;
                            double_word_program_select_q <= 1'b0;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Array strobes; the array itself applies ones-to-zeros only programming.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flashProgPulse    <= 1'b0;
            flashErasePulse   <= 1'b0;
            flashPreProgPulse <= 1'b0;
        end else begin
            flashProgPulse    <= (state_q == ST_PROG) && opDone;
            flashErasePulse   <= (state_q == ST_ERASE) && opDone;
            flashPreProgPulse <= (state_q == ST_PRE) && (count_q == 16'h0001);
        end
    end

    // Busy mirrors its flags one cycle late, like every other output.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            flashBankBusy <= 2'h0;
        else
            flashBankBusy <= {busyMain_q, busyExt_q};
    end

    // Ack is registered, so every access costs one wait state and never stands two cycles.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wbRead | wbWrite;
    end

    // Read data is valid in the cycle that carries ack and zero otherwise.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= 32'h00000000;
            if (wbRead) begin
                case (wb_adr_i)
                    `FWC_OFS_CTRL_HI:
                        wb_dat_o <= {16'h0000, start_q, suspend_request_q, wpg_q, double_word_program_select_q, ser_q,
                                     3'h0, modSel_q, 7'h00};
                    `FWC_OFS_SECT_LO:
                        wb_dat_o <= {22'h000000, sect_view(modSel_q, b0Sect_q, b2Sect_q)};
                    `FWC_OFS_STATUS:
                        wb_dat_o <= {28'h0000000, eraseSusp_q, progSusp_q,
                                     busyMain_q, busyExt_q};
                    `FWC_OFS_ERROR:
                        wb_dat_o <= {31'h00000000, errFlag};
                    default:
                        wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // fwc_flash_write_control

// File: tb/fwc_flash_write_control_chk.sv
module fwc_flash_write_control_chk (
    // System
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // Wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Flash array command interface
    input wire logic        flashError,
    input wire logic        flashProgPulse,
    input wire logic        flashErasePulse,
    input wire logic        flashPreProgPulse,
    input wire logic [1:0]  flashBankBusy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_prog_busy: assert property (flashProgPulse |-> $past(|flashBankBusy))
        else $error("program ended on an idle bank");
    chk_busy_clear: assert property (flashProgPulse |-> ##[1:3] flashBankBusy == 2'b00)
        else $error("busy not cleared after program");
    chk_preprog_erase: assert property (flashPreProgPulse |-> ##[1:40] flashErasePulse)
        else $error("erase phase missing after pre-program");
    chk_erase_busy: assert property (flashErasePulse |-> $past(|flashBankBusy))
        else $error("erase ended on an idle bank");
    chk_one_module: assert property (flashBankBusy != 2'b11)
        else $error("both modules busy at once");
    chk_err_refuse: assert property ($rose(|flashBankBusy) |->
        !($past(flashError, 2) && $past(flashError, 3) && $past(flashError, 4)))
        else $error("operation started with error flag high");
endmodule // fwc_flash_write_control_chk

// File: tb/fwc_flash_write_control_tb.sv
`include "fwc_map.vh"
module fwc_flash_write_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        fErr = 1'b0, ack, pr, ep, pp;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] datI = 32'h0, datO, q;
    logic [1:0]  busy;
    int          fails = 0, comparisons = 0, pCnt = 0, eCnt = 0, ppCnt = 0;
    localparam logic [31:0] ST = 32'h1 << `FWC_BIT_START, SU = 32'h1 << `FWC_BIT_SUSPEND_REQUEST;
    localparam logic [31:0] WP = 32'h1 << `FWC_BIT_WPG, DW = 32'h1 << `FWC_BIT_DOUBLE_WORD_PROGRAM_SELECT;
    localparam logic [31:0] SE = 32'h1 << `FWC_BIT_SER, MS = 32'h1 << `FWC_BIT_MODSEL;
    localparam logic [3:0]  CT = `FWC_OFS_CTRL_HI, SC = `FWC_OFS_SECT_LO, SS = `FWC_OFS_STATUS;
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        pCnt <= pCnt + int'(pr);
        eCnt <= eCnt + int'(ep);
        ppCnt <= ppCnt + int'(pp);
    end
    fwc_flash_write_control i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_ack_o(ack), .flashError(fErr), .flashProgPulse(pr),
        .flashErasePulse(ep), .flashPreProgPulse(pp), .flashBankBusy(busy));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic single cycle: hold everything until ack is sampled, then release.
    task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        datI <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 40) chk("ack wait", 32'h0, 32'h1);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask
    task waitp(input logic er, input int tgt);
        int n;
        n = 0;
        while (n < 200 && (er ? eCnt : pCnt) != tgt) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (3) @(posedge clk_sys);
        chk(er ? "erase count" : "prog count", tgt, er ? eCnt : pCnt);
    endtask
    task wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(CT, 32'hFFFF, 32'h0, "ctrl reset");
        rd(SC, 32'hFFFF, 32'h0, "sector reset");
        rd(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
        xfer(1'b1, CT, ST | WP | DW);
        rd(SS, 32'h3, 32'h0, "two operations");
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, CT, ST | (k[1] ? DW : WP) | (k[0] ? MS : 32'h0));
            rd(SS, 32'h3, k[0] ? 32'h2 : 32'h1, "busy module");
            waitp(1'b0, k + 1);
            rd(CT, 32'hFFFF, 32'h0, "ctrl after program");
        end
        xfer(1'b1, CT, MS | SE);
        xfer(1'b1, SC, 32'hFFFF);
        rd(SC, 32'hFFFF, 32'h3FF, "bank0 bits");
        xfer(1'b1, CT, SE);
        xfer(1'b1, SC, 32'hFFFF);
        rd(SC, 32'hFFFF, 32'h7, "bank2 bits");
        xfer(1'b1, CT, ST | SE);
        xfer(1'b1, CT, SE);
        rd(CT, ST, ST, "start held");
        rd(SC, 32'hFFFF, 32'h7, "sector status");
        waitp(1'b1, 1);
        chk("preprog count", 32'h1, ppCnt);
        rd(CT, 32'hFFFF, 32'h0, "ctrl after erase");
        rd(SC, 32'hFFFF, 32'h0, "status after erase");
        xfer(1'b1, CT, ST | SE | MS);
        rd(SS, 32'h3, 32'h0, "erase no sector");
        xfer(1'b1, SC, 32'h201);
        xfer(1'b1, CT, ST | SE | MS);
        xfer(1'b1, CT, SU | SE | MS);
        rd(SS, 32'hF, 32'h8, "erase suspended");
        rd(SC, 32'hFFFF, 32'h201, "suspend status");
        xfer(1'b1, CT, ST | SU | SE | MS);
        rd(SS, 32'h3, 32'h0, "start with suspend");
        xfer(1'b1, CT, SE | MS);
        xfer(1'b1, CT, ST | WP);
        rd(SS, 32'h3, 32'h1, "program in erase suspend");
        waitp(1'b0, 5);
        xfer(1'b1, CT, ST | SE | MS);
        rd(SS, 32'h3, 32'h2, "erase resumed");
        waitp(1'b1, 2);
        xfer(1'b1, CT, ST | WP);
        xfer(1'b1, CT, SU | WP);
        xfer(1'b1, CT, WP);
        xfer(1'b1, CT, ST | DW);
        rd(SS, 32'h7, 32'h4, "program suspend refuses");
        xfer(1'b1, CT, ST | WP);
        waitp(1'b0, 6);
        fErr <= 1'b1;
        repeat (4) @(posedge clk_sys);
        xfer(1'b1, CT, ST | WP);
        rd(CT, ST, 32'h0, "start with error");
        rd(SS, 32'h3, 32'h0, "busy with error");
        rd(`FWC_OFS_ERROR, 32'h1, 32'h1, "error flag");
        fErr <= 1'b0;
        wrap_up();
    end
endmodule // fwc_flash_write_control_tb
bind fwc_flash_write_control fwc_flash_write_control_chk i_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .flashError(flashError), .flashProgPulse(flashProgPulse),
    .flashErasePulse(flashErasePulse), .flashPreProgPulse(flashPreProgPulse),
    .flashBankBusy(flashBankBusy));
